// ===== design/ppm_port_mux.sv
// Notes on behaviour
// RL1: Pin32 clock setting wins, else I2C data
// RL2: Pin32 otherwise general I/O, interrupt always sampled
// RL3: Open-drain bit: drive low only; code keeps pin30 transmit data push-pull, driving high
// RL4: Receiver on makes pin31 receive input
// RL5: Transmitter on makes pin30 transmit output
// RL6: Eight-pin input port never drives
// RL7: Eight-pin levels read, writes ignored
// RL8: Four-pin input port never drives
// RL9: Four-pin levels read in bits 3..0
// RL10: Port A: general, address, serial functions
// RL11: Port A per-pin software pull-up
// RL12: Port A direction write-only, reads undefined
// RL13: Mode 7: direction bit picks output/input
// RL14: Modes 4-6: address field overrides direction
// RL15: Non-address pins follow direction bits
// RL16: Port A data four bits, reset zero
// RL17: Pin-state read: data if output, else pin
//
// Purpose: Pin function mux for port three low pins, port A, input ports
// Assumes: Pins synchronous to mclk_i; serial/I2C units external
// Notes:   Port A serial pins left to serial unit, not muxed here
`timescale 1ns/1ns
module ppm_port_mux
  import ppm_pkg::*;
#(
  parameter int P4_W = 8
) (
  input  wire logic            mclk_i,
  input  wire logic            srst_i,
  input  wire logic [3:0]      addr_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic            wr_i,
  input  wire logic            rd_i,
  output logic      [7:0]      rdata_o,
  input  wire logic [2:0]      p3_pin_i,
  output logic      [2:0]      p3_pin_o,
  output logic      [2:0]      p3_pin_oe_o,
  input  wire logic            serial0_clock_out_i,
  output logic                 serial0_clock_in_o,
  output logic                 serial0_receive_o,
  input  wire logic            serial0_transmit_i,
  input  wire logic            iic1_data_out_i,
  output logic                 iic1_data_in_o,
  output logic                 ext_interrupt_four_o,
  input  wire logic [P4_W-1:0] p4_pin_i,
  input  wire logic [3:0]      p9_pin_i,
  input  wire logic [3:0]      pa_pin_i,
  input  wire logic [3:0]      pa_addr_i,
  output logic      [3:0]      pa_pin_o,
  output logic      [3:0]      pa_pin_oe_o,
  output logic      [3:0]      pa_pullup_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] p3_dir;
  logic [2:0] p3_data;
  logic [2:0] p3_od;
  logic [3:0] pa_direction_select;
  logic [3:0] pa_output_latch;
  logic [3:0] pa_pullup_ctrl;
  logic [3:0] pa_open_drain_ctrl;
  logic [3:0] address_enable_field;
  ppm_mode_t  op_mode;
  logic [5:0] ser_ctrl;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      p3_dir  <= PPM_P3_RST;
      p3_data <= PPM_P3_RST;
      p3_od   <= PPM_P3_RST;
    end else if (wr_i) begin
      if (addr_i == PPM_OFF_P3_DIR)  p3_dir  <= wdata_i[2:0];
      if (addr_i == PPM_OFF_P3_DATA) p3_data <= wdata_i[2:0];
      if (addr_i == PPM_OFF_P3_OD)   p3_od   <= wdata_i[2:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pa_direction_select  <= PPM_PA_RST;
      pa_output_latch      <= PPM_PA_RST; // RL16
      pa_pullup_ctrl       <= PPM_PA_RST;
      pa_open_drain_ctrl   <= PPM_PA_RST;
      address_enable_field <= PPM_AE_RST;
    end else if (wr_i) begin
      if (addr_i == PPM_OFF_PA_DIR)   pa_direction_select  <= wdata_i[3:0];
      if (addr_i == PPM_OFF_PA_DATA)  pa_output_latch      <= wdata_i[3:0]; // RL16
      if (addr_i == PPM_OFF_PA_PULL)  pa_pullup_ctrl       <= wdata_i[3:0]; // RL11
      if (addr_i == PPM_OFF_PA_OD)    pa_open_drain_ctrl   <= wdata_i[3:0];
      if (addr_i == PPM_OFF_PIN_FUNC) address_enable_field <= wdata_i[3:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      op_mode  <= PPM_MODE_7;
      ser_ctrl <= PPM_SC_RST;
    end else if (wr_i) begin
      if (addr_i == PPM_OFF_MODE && wdata_i[2]) op_mode <= ppm_mode_t'(wdata_i[2:0]);
      if (addr_i == PPM_OFF_SER_CTRL) ser_ctrl <= wdata_i[5:0];
    end
  end

  // ----------------------------------------
  // Port three pin selection
  // ----------------------------------------
  logic       iic_en;
  logic       ck_lo;
  logic       ck_hi;
  logic       sync_sel;
  logic       p32_iic;
  logic       p32_ck_in;
  logic       p32_ck_out;
  logic [2:0] next_p3_o;
  logic [2:0] next_p3_oe;

  assign iic_en     = ser_ctrl[PPM_SC_IIC_EN];
  assign ck_lo      = ser_ctrl[PPM_SC_CKLO];
  assign ck_hi      = ser_ctrl[PPM_SC_CKHI];
  assign sync_sel   = ser_ctrl[PPM_SC_SYNC];
  assign p32_iic    = iic_en && !ck_hi && !ck_lo && !sync_sel; // RL1
  assign p32_ck_in  = !p32_iic && ck_hi; // RL1
  assign p32_ck_out = !p32_iic && !ck_hi && (sync_sel || ck_lo); // RL1

  always_comb begin
    next_p3_o  = p3_data;
    next_p3_oe = p3_dir;
    // Pin 30: transmit data overrides direction
    if (ser_ctrl[PPM_SC_TX_ON]) begin // RL5
      next_p3_o[0]  = serial0_transmit_i;
      next_p3_oe[0] = 1'b1;
    end
    // Pin 31: receive input overrides direction
    if (ser_ctrl[PPM_SC_RX_ON]) begin // RL4
      next_p3_oe[1] = 1'b0;
    end
    // Pin 32
    if (p32_iic) begin // RL1
      next_p3_o[2]  = 1'b0;
      next_p3_oe[2] = !iic1_data_out_i;
    end else if (p32_ck_in) begin
      next_p3_oe[2] = 1'b0;
    end else if (p32_ck_out) begin
      next_p3_o[2]  = serial0_clock_out_i;
      next_p3_oe[2] = 1'b1;
    end
    // Open drain: drive low only, float high
    for (int i = 0; i < PPM_P3_W; i++) begin
      // Transmit data stays push-pull; only general and clock outputs go open drain
      if (p3_od[i] && !(i == 2 && p32_iic) && !(i == 0 && ser_ctrl[PPM_SC_TX_ON]) && next_p3_oe[i]) begin // RL3
        next_p3_oe[i] = !next_p3_o[i];
        next_p3_o[i]  = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      p3_pin_o             <= PPM_P3_RST;
      p3_pin_oe_o          <= PPM_P3_RST;
      serial0_clock_in_o   <= 1'b0;
      serial0_receive_o    <= 1'b1;
      iic1_data_in_o       <= 1'b1;
      ext_interrupt_four_o <= 1'b0;
    end else begin
      p3_pin_o             <= next_p3_o; // RL2
      p3_pin_oe_o          <= next_p3_oe; // RL2
      serial0_clock_in_o   <= p3_pin_i[2];
      serial0_receive_o    <= p3_pin_i[1]; // RL4
      iic1_data_in_o       <= p3_pin_i[2];
      ext_interrupt_four_o <= p3_pin_i[2]; // RL2
    end
  end

  // ----------------------------------------
  // Port A pin selection
  // ----------------------------------------
  logic [3:0] pa_is_addr;
  logic [3:0] next_pa_o;
  logic [3:0] next_pa_oe;
  logic       addr_mode;
  localparam logic [3:0] AE_THR [4] = '{PPM_AE_PA3, PPM_AE_PA2, PPM_AE_PA1, PPM_AE_PA0};

  assign addr_mode = (op_mode != PPM_MODE_7);

  generate
    for (genvar g = 0; g < PPM_PA_W; g++) begin : g_pa
      assign pa_is_addr[g] = addr_mode && (address_enable_field >= AE_THR[3-g]); // RL14
      always_comb begin
        if (pa_is_addr[g]) begin // RL14
          next_pa_o[g]  = pa_addr_i[g];
          next_pa_oe[g] = 1'b1;
        end else if (pa_direction_select[g]) begin // RL13 RL15 RL10
          next_pa_o[g]  = pa_open_drain_ctrl[g] ? 1'b0 : pa_output_latch[g];
          next_pa_oe[g] = pa_open_drain_ctrl[g] ? !pa_output_latch[g] : 1'b1;
        end else begin
          next_pa_o[g]  = 1'b0;
          next_pa_oe[g] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pa_pin_o    <= PPM_PA_RST;
      pa_pin_oe_o <= PPM_PA_RST;
      pa_pullup_o <= PPM_PA_RST;
    end else begin
      pa_pin_o    <= next_pa_o;
      pa_pin_oe_o <= next_pa_oe;
      pa_pullup_o <= pa_pullup_ctrl & ~next_pa_oe; // RL11
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] next_rdata;
  logic [3:0] pa_state;

  assign pa_state = (pa_direction_select & pa_output_latch) | (~pa_direction_select & pa_pin_i); // RL17

  always_comb begin
    next_rdata = PPM_RD_UNMAP;
    unique case (addr_i)
      PPM_OFF_P3_DATA:  next_rdata[2:0] = p3_data;
      PPM_OFF_P3_STATE: next_rdata[2:0] = (p3_dir & p3_data) | (~p3_dir & p3_pin_i);
      PPM_OFF_P3_OD:    next_rdata[2:0] = p3_od;
      PPM_OFF_P4_LVL:   next_rdata      = p4_pin_i[7:0]; // RL7 RL6
      PPM_OFF_P9_LVL:   next_rdata[3:0] = p9_pin_i; // RL9 RL8
      PPM_OFF_PA_DATA:  next_rdata[3:0] = pa_output_latch;
      PPM_OFF_PA_STATE: next_rdata[3:0] = pa_state; // RL17
      PPM_OFF_PA_PULL:  next_rdata[3:0] = pa_pullup_ctrl;
      PPM_OFF_PA_OD:    next_rdata[3:0] = pa_open_drain_ctrl;
      PPM_OFF_PIN_FUNC: next_rdata[3:0] = address_enable_field;
      PPM_OFF_MODE:     next_rdata[2:0] = op_mode;
      PPM_OFF_SER_CTRL: next_rdata[5:0] = ser_ctrl;
      default:          next_rdata      = PPM_RD_UNMAP; // RL12
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) rdata_o <= PPM_RD_UNMAP;
    else if (rd_i) rdata_o <= next_rdata;
    else rdata_o <= PPM_RD_UNMAP;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_iic_data_pin: assert property (@(posedge mclk_i) disable iff (srst_i) // RL1
    p32_iic |=> (p3_pin_o[2] == 1'b0)) else $error("iic data pin drives high");
  a_clk_in_pin: assert property (@(posedge mclk_i) disable iff (srst_i) // RL1
    p32_ck_in |=> !p3_pin_oe_o[2]) else $error("clock input pin driven");
  a_open_drain: assert property (@(posedge mclk_i) disable iff (srst_i) // RL3
    p3_od[0] && !ser_ctrl[PPM_SC_TX_ON] |=> !(p3_pin_oe_o[0] && p3_pin_o[0])) else $error("open drain drives high");
  a_rx_input: assert property (@(posedge mclk_i) disable iff (srst_i) // RL4
    ser_ctrl[PPM_SC_RX_ON] |=> !p3_pin_oe_o[1]) else $error("receive pin driven");
  a_tx_output: assert property (@(posedge mclk_i) disable iff (srst_i) // RL5
    ser_ctrl[PPM_SC_TX_ON] |=> p3_pin_oe_o[0] && p3_pin_o[0] == $past(serial0_transmit_i))
    else $error("transmit pin not driven");
  a_p4_read: assert property (@(posedge mclk_i) disable iff (srst_i) // RL7
    rd_i && addr_i == PPM_OFF_P4_LVL |=> rdata_o == $past(p4_pin_i[7:0])) else $error("port four read wrong");
  a_pa_addr_out: assert property (@(posedge mclk_i) disable iff (srst_i) // RL14
    pa_is_addr[3] |=> pa_pin_oe_o[3] && pa_pin_o[3] == $past(pa_addr_i[3])) else $error("address pin wrong");
  a_pa_mode7: assert property (@(posedge mclk_i) disable iff (srst_i) // RL13
    op_mode == PPM_MODE_7 && !pa_direction_select[0] |=> !pa_pin_oe_o[0]) else $error("input pin driven");
  a_pa_state: assert property (@(posedge mclk_i) disable iff (srst_i) // RL17
    rd_i && addr_i == PPM_OFF_PA_STATE |=> rdata_o[3:0] == $past(pa_state)) else $error("pin state read wrong");
  c_iic_mode: cover property (@(posedge mclk_i) p32_iic);
  c_clk_out: cover property (@(posedge mclk_i) p32_ck_out);
  c_addr_mode: cover property (@(posedge mclk_i) pa_is_addr[0]);
endmodule

// ===== design/ppm_pkg.sv
// Purpose: Constants for the port pin mux and input port block
// Assumes: Byte-wide register port, offsets chosen locally
// Notes:   Pin groups: port three low pins, input ports, port A
package ppm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] PPM_OFF_P3_DIR   = 4'h0;
  localparam logic [3:0] PPM_OFF_P3_DATA  = 4'h1;
  localparam logic [3:0] PPM_OFF_P3_STATE = 4'h2;
  localparam logic [3:0] PPM_OFF_P3_OD    = 4'h3;
  localparam logic [3:0] PPM_OFF_P4_LVL   = 4'h4;
  localparam logic [3:0] PPM_OFF_P9_LVL   = 4'h5;
  localparam logic [3:0] PPM_OFF_PA_DIR   = 4'h6;
  localparam logic [3:0] PPM_OFF_PA_DATA  = 4'h7;
  localparam logic [3:0] PPM_OFF_PA_STATE = 4'h8;
  localparam logic [3:0] PPM_OFF_PA_PULL  = 4'h9;
  localparam logic [3:0] PPM_OFF_PA_OD    = 4'ha;
  localparam logic [3:0] PPM_OFF_PIN_FUNC = 4'hb;
  localparam logic [3:0] PPM_OFF_MODE     = 4'hc;
  localparam logic [3:0] PPM_OFF_SER_CTRL = 4'hd;
  // ----------------------------------------
  // Widths, resets, fields
  // ----------------------------------------
  localparam int         PPM_P3_W      = 3;
  localparam int         PPM_PA_W      = 4;
  localparam int         PPM_P9_W      = 4;
  localparam logic [7:0] PPM_RD_UNMAP  = 8'h00;
  localparam logic [3:0] PPM_PA_RST    = 4'h0;
  localparam logic [2:0] PPM_P3_RST    = 3'h0;
  localparam logic [3:0] PPM_AE_RST    = 4'h0;
  // Address-enable threshold per port A pin (field >= value gives address)
  localparam logic [3:0] PPM_AE_PA3    = 4'hc;
  localparam logic [3:0] PPM_AE_PA2    = 4'hb;
  localparam logic [3:0] PPM_AE_PA1    = 4'ha;
  localparam logic [3:0] PPM_AE_PA0    = 4'h9;
  // Serial/I2C control bits
  localparam int         PPM_SC_IIC_EN = 0;
  localparam int         PPM_SC_SYNC   = 1;
  localparam int         PPM_SC_CKLO   = 2;
  localparam int         PPM_SC_CKHI   = 3;
  localparam int         PPM_SC_RX_ON  = 4;
  localparam int         PPM_SC_TX_ON  = 5;
  localparam logic [5:0] PPM_SC_RST    = 6'h00;
  // Operating modes
  typedef enum logic [2:0] {
    PPM_MODE_4 = 3'b100,
    PPM_MODE_5 = 3'b101,
    PPM_MODE_6 = 3'b110,
    PPM_MODE_7 = 3'b111
  } ppm_mode_t;
  localparam logic [2:0] PPM_MODE_RST  = 3'b111;
endpackage

// ===== tb/ppm_pin_model.sv
// Purpose: Far-side pins for the port pin mux
// Assumes: Bench sets what the outside world drives
// Notes:   Released pins rest at the pull level, else flip
`timescale 1ns/1ns
module ppm_pin_model (
  input  wire logic [2:0] p3_out_i,
  input  wire logic [2:0] p3_oe_i,
  input  wire logic [2:0] p3_ext_i,
  input  wire logic [2:0] p3_ext_en_i,
  input  wire logic [3:0] pa_out_i,
  input  wire logic [3:0] pa_oe_i,
  input  wire logic [3:0] pa_pull_i,
  input  wire logic [3:0] pa_ext_i,
  input  wire logic [3:0] pa_ext_en_i,
  output logic      [2:0] p3_lvl_o,
  output logic      [3:0] pa_lvl_o
);
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      // Board pull-up holds an open-drain line high
      p3_lvl_o[i] = p3_oe_i[i] ? p3_out_i[i] : (p3_ext_en_i[i] ? p3_ext_i[i] : 1'b1);
    end
    for (int i = 0; i < 4; i++) begin
      pa_lvl_o[i] = pa_oe_i[i] ? pa_out_i[i] :
                    (pa_ext_en_i[i] ? pa_ext_i[i] : (pa_pull_i[i] | ~pa_out_i[i]));
    end
  end
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the port pin mux
// Assumes: Offsets and fields from ppm_pkg
// Notes:   Input-only ports are plain bench drives
`timescale 1ns/1ns
module tb
  import ppm_pkg::*;
;
  logic       mclk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, s_clk = 0, s_tx = 0, iic_out = 1;
  logic [3:0] addr_i = 0, p9 = 0, pa_addr = 0, pa_ext = 0, pa_en = 0;
  logic [7:0] wdata_i = 0, p4 = 0, rdata;
  logic [2:0] p3_o, p3_oe, p3_lvl, p3_ext = 0, p3_en = 0;
  logic [3:0] pa_o, pa_oe, pa_pu, pa_lvl;
  logic       clk_in, rx_o, iic_in, irq;
  logic [7:0] ctl [5] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h05};
  logic [4:0] oe2     = 5'b11110;
  logic [4:0] lvl     = 5'b10111;
  int         n_errors = 0, cmp_count = 0, cyc = 0;

  always #20 mclk_i = ~mclk_i;

  ppm_port_mux dut (
    .mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata), .p3_pin_i(p3_lvl), .p3_pin_o(p3_o), .p3_pin_oe_o(p3_oe),
    .serial0_clock_out_i(s_clk), .serial0_clock_in_o(clk_in), .serial0_receive_o(rx_o),
    .serial0_transmit_i(s_tx), .iic1_data_out_i(iic_out), .iic1_data_in_o(iic_in),
    .ext_interrupt_four_o(irq), .p4_pin_i(p4), .p9_pin_i(p9), .pa_pin_i(pa_lvl), .pa_addr_i(pa_addr),
    .pa_pin_o(pa_o), .pa_pin_oe_o(pa_oe), .pa_pullup_o(pa_pu));

  ppm_pin_model pins (
    .p3_out_i(p3_o), .p3_oe_i(p3_oe), .p3_ext_i(p3_ext), .p3_ext_en_i(p3_en), .pa_out_i(pa_o),
    .pa_oe_i(pa_oe), .pa_pull_i(pa_pu), .pa_ext_i(pa_ext), .pa_ext_en_i(pa_en),
    .p3_lvl_o(p3_lvl), .pa_lvl_o(pa_lvl));

  // ----------------------------------------
  // Access and check tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    chk(rdata, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      report_and_stop;
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    rdchk(PPM_OFF_PA_DATA, 8'h00);
    rdchk(PPM_OFF_PA_DIR, PPM_RD_UNMAP);
    rdchk(4'hf, PPM_RD_UNMAP);
    $display("test reset done");
    p4 <= 8'ha5;
    p9 <= 4'h6;
    wr(PPM_OFF_P4_LVL, 8'h00);
    settle;
    rdchk(PPM_OFF_P4_LVL, 8'ha5);
    rdchk(PPM_OFF_P9_LVL, 8'h06);
    $display("test input ports done");
    pa_ext <= 4'ha;
    pa_en  <= 4'hf;
    wr(PPM_OFF_PA_DIR, 8'h05);
    wr(PPM_OFF_PA_DATA, 8'h03);
    wr(PPM_OFF_PA_PULL, 8'h0f);
    settle;
    chk(pa_oe, 4'h5);
    chk(pa_o & 4'h5, 4'h1);
    chk(pa_pu, 4'ha);
    rdchk(PPM_OFF_PA_DATA, 8'h03);
    rdchk(PPM_OFF_PA_STATE, 8'h0b);
    pa_addr <= 4'h6;
    wr(PPM_OFF_PIN_FUNC, 8'h0b);
    for (int m = 4; m < 7; m++) begin
      wr(PPM_OFF_MODE, 8'(m));
      settle;
      chk(pa_oe, 4'h7);
      chk(pa_o & 4'h7, 4'h6);
      chk(pa_pu, 4'h8);
    end
    wr(PPM_OFF_PIN_FUNC, 8'h0c);
    settle;
    chk({pa_oe, pa_o}, 8'hf6);
    wr(PPM_OFF_PIN_FUNC, 8'h00);
    settle;
    chk(pa_oe, 4'h5);
    wr(PPM_OFF_PIN_FUNC, 8'h0c);
    wr(PPM_OFF_MODE, 8'h07);
    settle;
    chk(pa_oe, 4'h5);
    wr(PPM_OFF_MODE, 8'h03);
    rdchk(PPM_OFF_MODE, 8'h07);
    wr(PPM_OFF_PA_OD, 8'h01);
    settle;
    chk(pa_oe, 4'h4);
    chk(pa_pu, 4'hb);
    $display("test port a done");
    p3_en <= 3'h2;
    wr(PPM_OFF_P3_DIR, 8'h07);
    wr(PPM_OFF_P3_DATA, 8'h05);
    wr(PPM_OFF_SER_CTRL, 8'h30);
    settle;
    chk(p3_oe, 3'h5);
    chk(p3_o & 3'h5, 3'h4);
    chk(rx_o, 1'b0);
    wr(PPM_OFF_SER_CTRL, 8'h00);
    settle;
    chk({p3_oe, p3_o}, 6'h3d);
    s_clk   <= 1'b1;
    iic_out <= 1'b0;
    p3_en   <= 3'h0;
    for (int i = 0; i < 5; i++) begin
      wr(PPM_OFF_SER_CTRL, ctl[i]);
      settle;
      chk(p3_oe[2], oe2[i]);
      chk({irq, clk_in, iic_in}, {3{lvl[i]}});
    end
    wr(PPM_OFF_SER_CTRL, 8'h00);
    wr(PPM_OFF_P3_OD, 8'h04);
    settle;
    chk(p3_oe, 3'h3);
    wr(PPM_OFF_P3_DATA, 8'h01);
    settle;
    chk({p3_oe, p3_o}, 6'h39);
    wr(PPM_OFF_SER_CTRL, 8'h04);
    settle;
    chk(p3_oe[2], 1'b0);
    s_tx <= 1'b1;
    wr(PPM_OFF_P3_OD, 8'h05);
    settle;
    chk(p3_oe[0], 1'b0);
    wr(PPM_OFF_SER_CTRL, 8'h20);
    settle;
    chk({p3_oe[0], p3_o[0]}, 2'h3);
    $display("test port three done");
    report_and_stop;
  end
endmodule
